// File: design/system_configuration_memtype.sv
`timescale 1ns/1ps
`include "system_configuration_regs.svh"

module scr_memtype
   import scr_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        force_wb_i,
   input  wire logic        tom2_en_i,
   input  wire scr_mtq_t    q_i,
   output logic [2:0]       type_o,
   output scr_src_t         src_o
);

   wire logic  above_4g;
   wire logic  below_tom2;
   wire logic  force_hit;
   wire logic  ovr_hit;
   wire logic [2:0] ovr_type;
   wire logic [2:0] next_type;
   scr_src_t        next_src;

   assign above_4g   = q_i.frame >= `SCR_FOUR_GB;
   assign below_tom2 = q_i.frame < q_i.tom2_frame;
   assign force_hit  = force_wb_i & q_i.deftype_en & tom2_en_i & above_4g & below_tom2;
   assign ovr_hit    = q_i.page_attr_hit | q_i.var_hit;
   assign ovr_type   = q_i.page_attr_hit ? q_i.page_attr_type : q_i.var_type;
   assign next_type  = ovr_hit ? ovr_type : (force_hit ? `SCR_TYPE_WB : q_i.deftype);
   assign next_src   = ovr_hit ? SCR_SRC_OVR : (force_hit ? SCR_SRC_WB : SCR_SRC_DEF);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         type_o <= `SCR_TYPE_RESET;
         src_o  <= SCR_SRC_DEF;
      end else if (ce_i) begin
         type_o <= next_type;
         src_o  <= next_src;
      end
   end

endmodule

// File: design/system_configuration_top.sv
`timescale 1ns/1ps
`include "system_configuration_regs.svh"

module scr_top
   import scr_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire scr_req_t    req_i,
   input  wire logic        mgmt_lock_i,
   input  wire logic [1:0]  attr_wdata_i,
   input  wire logic        attr_wr_i,
   input  wire scr_mtq_t    mtq_i,
   output logic [63:0]      rdata_o,
   output logic             hit_o,
   output logic [1:0]       attr_rdata_o,
   output logic [1:0]       attr_eff_o,
   output scr_feat_t        feat_o,
   output logic [2:0]       mem_type_o,
   output scr_src_t         mem_src_o
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [63:0] system_configuration;
   logic [1:0]  dram_attr;
   logic [63:0] next_cfg;

   wire logic        sel;
   wire logic        wr_en;
   wire logic [63:0] cur;
   wire logic [63:0] wd;
   wire logic        next_fix_en;
   wire logic        next_mod_en;
   wire logic        next_var_en;
   wire logic        next_tom2_en;
   wire logic        next_force_wb;
   wire logic        next_mem_enc;
   wire logic        next_page_int;
   wire logic        next_priv_lvl;
   wire logic        mod_allowed;

   assign sel   = req_i.addr == `SCR_ADDR;
   assign wr_en = ce_i & req_i.wr & sel;
   assign cur   = system_configuration;
   assign wd    = req_i.wdata;

   // ------------------------------------------------------------
   // write policy per bit
   // ------------------------------------------------------------
   // plain read/write bits
   assign next_fix_en   = wd[`SCR_FIX_DRAM_EN];
   assign next_mod_en   = wd[`SCR_FIX_DRAM_MOD];
   assign next_var_en   = wd[`SCR_VAR_EN];
   assign next_tom2_en  = wd[`SCR_TOM2_EN];
   assign next_force_wb = wd[`SCR_FORCE_WB];

   assign next_mem_enc  = (mgmt_lock_i & cur[`SCR_MEM_ENC]) ? 1'b1 : wd[`SCR_MEM_ENC];

   assign next_page_int = cur[`SCR_PAGE_INT] ? 1'b1 : (wd[`SCR_PAGE_INT] & next_mem_enc);

   assign next_priv_lvl = cur[`SCR_PAGE_INT] ? cur[`SCR_PRIV_LVL] : wd[`SCR_PRIV_LVL];

   // undefined bits stay zero whatever software writes
   always_comb begin
      next_cfg                    = `SCR_RESET;
      next_cfg[`SCR_FIX_DRAM_EN]  = next_fix_en;
      next_cfg[`SCR_FIX_DRAM_MOD] = next_mod_en;
      next_cfg[`SCR_VAR_EN]       = next_var_en;
      next_cfg[`SCR_TOM2_EN]      = next_tom2_en;
      next_cfg[`SCR_FORCE_WB]     = next_force_wb;
      next_cfg[`SCR_MEM_ENC]      = next_mem_enc;
      next_cfg[`SCR_PAGE_INT]     = next_page_int;
      next_cfg[`SCR_PRIV_LVL]     = next_priv_lvl;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         system_configuration <= `SCR_RESET;
      end else if (wr_en) begin
         system_configuration <= next_cfg & `SCR_DEFINED_MASK;
      end
   end

   // ------------------------------------------------------------
   // fixed-range dram attribute pair
   // ------------------------------------------------------------
   // modify enable gates access
   assign mod_allowed = cur[`SCR_FIX_DRAM_MOD];

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         dram_attr <= `SCR_ATTR_RESET;
      end else if (ce_i & attr_wr_i & mod_allowed) begin
         dram_attr <= attr_wdata_i;
      end
   end

   assign attr_rdata_o = mod_allowed ? dram_attr : 2'h0;
   assign attr_eff_o   = cur[`SCR_FIX_DRAM_EN] ? dram_attr : 2'h0;

   // ------------------------------------------------------------
   // read path and feature outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_o <= `SCR_RESET;
         hit_o   <= 1'b0;
      end else if (ce_i) begin
         rdata_o <= (req_i.rd & sel) ? cur : 64'h0;
         hit_o   <= (req_i.rd | req_i.wr) & sel;
      end
   end

   assign feat_o = '{fix_dram_attr: cur[`SCR_FIX_DRAM_EN],
                     var_range:     cur[`SCR_VAR_EN],
                     second_top:    cur[`SCR_TOM2_EN],
                     mem_enc:       cur[`SCR_MEM_ENC],
                     page_int:      cur[`SCR_PAGE_INT],
                     priv_lvl:      cur[`SCR_PRIV_LVL]};

   // ------------------------------------------------------------
   // default memory type resolution
   // ------------------------------------------------------------
   scr_memtype u_memtype (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .force_wb_i (cur[`SCR_FORCE_WB]),
      .tom2_en_i  (cur[`SCR_TOM2_EN]),
      .q_i        (mtq_i),
      .type_o     (mem_type_o),
      .src_o      (mem_src_o)
   );

endmodule

// File: inc/system_configuration_pkg.sv
package scr_pkg;

   // register access request from the privileged msr path
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [63:0] wdata;
   } scr_req_t;

   // memory-type query for one physical page (4 KiB frame number)
   typedef struct packed {
      logic [51:0] frame;
      logic [51:0] tom2_frame;
      logic        deftype_en;
      logic [2:0]  deftype;
      logic        var_hit;
      logic [2:0]  var_type;
      logic        page_attr_hit;
      logic [2:0]  page_attr_type;
   } scr_mtq_t;

   typedef struct packed {
      logic fix_dram_attr;
      logic var_range;
      logic second_top;
      logic mem_enc;
      logic page_int;
      logic priv_lvl;
   } scr_feat_t;

   typedef enum logic [2:0] {
      SCR_SRC_DEF  = 3'b001,
      SCR_SRC_WB   = 3'b010,
      SCR_SRC_OVR  = 3'b100
   } scr_src_t;

endpackage

// File: inc/system_configuration_regs.svh
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

`define SCR_ADDR          32'hc0010010
`define SCR_WIDTH         64
`define SCR_RESET         64'h0000000000000000
`define SCR_FIX_DRAM_EN   18
`define SCR_FIX_DRAM_MOD  19
`define SCR_VAR_EN        20
`define SCR_TOM2_EN       21
`define SCR_FORCE_WB      22
`define SCR_MEM_ENC       23
`define SCR_PAGE_INT      24
`define SCR_PRIV_LVL      25
`define SCR_DEFINED_MASK  64'h0000000003fc0000
`define SCR_TYPE_WB       3'h6
`define SCR_TYPE_RESET    3'h0
`define SCR_ATTR_RESET    2'h0
`define SCR_FOUR_GB       52'h0000000100000

`endif

// File: verification/scr_assertions.sv
`timescale 1ns/1ps
module scr_assertions
   import scr_pkg::*;
(
   input wire logic         sys_clk_i,
   input wire logic         rst_i,
   input wire logic         ce_i,
   input wire scr_req_t     req_i,
   input wire logic         mgmt_lock_i,
   input wire scr_mtq_t     mtq_i,
   input wire logic [63:0]  rdata_o,
   input wire logic         hit_o,
   input wire logic [1:0]   attr_eff_o,
   input wire scr_feat_t    feat_o,
   input wire logic [2:0]   mem_type_o,
   input wire scr_src_t     mem_src_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_reg_read;
      ce_i && req_i.rd && !req_i.wr && req_i.addr == 32'hc0010010;
   endsequence
   a_read_echo: assert property (s_reg_read |=>
      {rdata_o[18], rdata_o[20], rdata_o[21], rdata_o[23], rdata_o[24], rdata_o[25]} == $past(feat_o))
      else $error("read data stale");
   a_hit_flag: assert property (ce_i && (req_i.rd || req_i.wr) && req_i.addr == 32'hc0010010 |=> hit_o)
      else $error("hit missing");
   a_enc_lock: assert property (mgmt_lock_i && feat_o.mem_enc |=> feat_o.mem_enc)
      else $error("locked enable cleared");
   a_int_sticky: assert property (feat_o.page_int |=> feat_o.page_int)
      else $error("integrity bit cleared");
   a_int_needs_enc: assert property ($rose(feat_o.page_int) |-> feat_o.mem_enc)
      else $error("integrity set without encryption");
   a_priv_frozen: assert property (feat_o.page_int |=> $stable(feat_o.priv_lvl))
      else $error("privilege bit changed");
   a_attr_gate: assert property (!feat_o.fix_dram_attr |-> attr_eff_o == 2'h0)
      else $error("attributes leak");
   a_table_wins: assert property (ce_i && mtq_i.page_attr_hit && mtq_i.page_attr_type == 3'h2 |=>
      mem_type_o == 3'h2 && mem_src_o == SCR_SRC_OVR) else $error("override lost");
   a_reset_clear: assert property ($fell(rst_i) |-> feat_o == '0 && !hit_o && rdata_o == 64'h0
      && mem_type_o == 3'h0 && mem_src_o == SCR_SRC_DEF) else $error("state not cleared by reset");
endmodule
bind scr_top scr_assertions u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
   .mgmt_lock_i(mgmt_lock_i), .mtq_i(mtq_i), .rdata_o(rdata_o), .hit_o(hit_o), .attr_eff_o(attr_eff_o),
   .feat_o(feat_o), .mem_type_o(mem_type_o), .mem_src_o(mem_src_o));

// File: verification/system_configuration_register_tb_top.sv
`timescale 1ns/1ps
module system_configuration_register_tb_top
   import scr_pkg::*;
;
   localparam logic [31:0] A = 32'hc0010010;
   logic         clk = 0, rst = 1, ce = 1, lock = 0, aw = 0, hit;
   logic [1:0]   ad = 0, ar, ae;
   logic [2:0]   mt_o;
   logic [63:0]  rdata, m = 0;
   logic [63:0]  q[$];
   scr_req_t     req = '0;
   scr_mtq_t     mtq = '0;
   scr_feat_t    feat;
   scr_src_t     src;
   int           n_mismatch = 0, samples_checked = 0, seed = 58;
   always #5 clk = ~clk;
   scr_top dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .req_i(req), .mgmt_lock_i(lock), .attr_wdata_i(ad),
      .attr_wr_i(aw), .mtq_i(mtq), .rdata_o(rdata), .hit_o(hit), .attr_rdata_o(ar), .attr_eff_o(ae),
      .feat_o(feat), .mem_type_o(mt_o), .mem_src_o(src));
   task chk(input logic ok);
      samples_checked++;
      if (ok !== 1'b1) $display("Error %0t: bad value", $time);
      n_mismatch += int'(ok !== 1'b1);
   endtask
   // expected register image after one write
   function automatic logic [63:0] nxt(input logic [63:0] o, w, input logic l);
      logic [63:0] n;
      n = w & 64'h3fc0000;
      n[23] = n[23] | (l & o[23]);
      n[24] = o[24] | (n[24] & n[23]);
      n[25] = o[24] ? o[25] : n[25];
      return n;
   endfunction
   task op(input logic r, w, input logic [31:0] a, input logic [63:0] d, input logic l);
      @(posedge clk);
      req <= '{r, w, a, d};
      lock <= l;
      @(posedge clk);
      req <= '0;
      if (a == A && (r | w)) q.push_back(r ? m : 64'h0);
      if (a == A && w) m = nxt(m, d, l);
      #1;
      chk(feat === {m[18], m[20], m[21], m[23], m[24], m[25]});
      chk(a == A || rdata === 64'h0);
   endtask
   // attr write and memtype query share one cycle
   task sd(input logic [1:0] d, input logic [51:0] f, input logic [2:0] c, input logic [6:0] e, input scr_src_t s);
      @(posedge clk);
      {aw, ad, mtq.frame} <= {1'b1, d, f};
      {mtq.deftype_en, mtq.var_hit, mtq.page_attr_hit} <= c;
      @(posedge clk);
      aw <= 1'b0;
      #1;
      chk({ar, ae, mt_o} === e && src === s);
   endtask
   always @(negedge clk)
      if (hit === 1'b1) chk(q.size() > 0 && rdata === q.pop_front());
   task summarize;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      summarize();
   end
   initial begin
      mtq.tom2_frame = 52'h200000;
      mtq.var_type = 3'h1;
      mtq.page_attr_type = 3'h2;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      op(1, 0, A, 0, 0);
      chk(src === SCR_SRC_DEF && mt_o === 3'h0 && ar === 2'h0);
      op(1, 1, A + 1, 64'h3fc0000, 0);
      op(1, 1, A, 64'h1000000, 0);
      sd(2'h3, 0, 3'h0, {2'h0, 2'h0, 3'h0}, SCR_SRC_DEF);
      op(0, 1, A, 64'h80000, 0);
      sd(2'h3, 0, 3'h0, {2'h3, 2'h0, 3'h0}, SCR_SRC_DEF);
      op(0, 1, A, 64'h40000, 0);
      sd(2'h1, 0, 3'h0, {2'h0, 2'h3, 3'h0}, SCR_SRC_DEF);
      op(0, 1, A, 64'h600000, 0);
      sd(2'h0, 52'h100000, 3'h4, 7'h06, SCR_SRC_WB);
      sd(2'h0, 52'hfffff, 3'h4, 7'h00, SCR_SRC_DEF);
      sd(2'h0, 52'h200000, 3'h4, 7'h00, SCR_SRC_DEF);
      sd(2'h0, 52'h100000, 3'h0, 7'h00, SCR_SRC_DEF);
      sd(2'h0, 52'h100000, 3'h6, 7'h01, SCR_SRC_OVR);
      sd(2'h0, 52'h100000, 3'h7, 7'h02, SCR_SRC_OVR);
      repeat (24) op(1, 1'($random(seed)), A, {$random(seed), $random(seed)}, 1'($random(seed)));
      op(1, 1, A, 64'h3800000, 1);
      op(1, 1, A, 64'h0, 1);
      op(1, 1, A, 64'h0, 0);
      op(1, 0, A, 0, 0);
      // clock enable low: a full write must be ignored
      @(posedge clk);
      ce <= 1'b0;
      req <= '{1'b1, 1'b1, A, 64'h3fc0000};
      @(posedge clk);
      ce <= 1'b1;
      req <= '0;
      #1;
      chk(feat === {m[18], m[20], m[21], m[23], m[24], m[25]} && hit === 1'b0);
      // reset in mid-run, with locked bits set
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      m = 64'h0;
      #1;
      chk(feat === 6'h0 && hit === 1'b0 && rdata === 64'h0 && {ar, ae, mt_o} === 7'h00);
      chk(src === SCR_SRC_DEF);
      op(1, 0, A, 0, 0);
      repeat (2) @(posedge clk);
      chk(q.size() == 0);
      summarize();
   end
endmodule
